/* tcm_pkg.sv */
`default_nettype none
package tcm_pkg;

	////////////////////////////////////////////////////////////////////////
	// Shared word area layout
	localparam int unsigned MEM_WORDS = 4300;
	localparam logic [12:0] DB_LAST = 13'h0F9F;    // Last user database word
	localparam logic [12:0] STAT_FIRST = 13'h0FA0; // Status area
	localparam logic [12:0] STAT_LAST = 13'h1003;
	localparam logic [12:0] CTRL_WORD = 13'h1004;  // control_block_code
	localparam logic [12:0] CTRL_LAST = 13'h1067;
	localparam logic [12:0] EVT_WORD = 13'h1068;   // event_block_code
	localparam logic [12:0] EVT_LAST = 13'h10CB;
	localparam logic [12:0] ADDR_LAST = 13'h10CB;
	localparam logic [12:0] WORD_STEP = 13'h0001;
	localparam logic [15:0] WORD_CLEAR = 16'h0000;

	////////////////////////////////////////////////////////////////////////
	// Block codes
	localparam logic [15:0] CODE_SPECIAL_MIN = 16'h26AC; // Codes above are special
	localparam logic [15:0] CODE_USER_CMD = 16'h26AD;
	localparam logic [15:0] CODE_LIST_CMD = 16'h26AE;
	localparam logic [15:0] CODE_EVENT = 16'h26AF;
	localparam logic [15:0] CODE_LIST_ERR = 16'h26DE;
	localparam logic [15:0] CODE_TIME_GET = 16'h26F2;
	localparam logic [15:0] CODE_TIME_SET = 16'h26F3;
	localparam logic [15:0] CODE_WARM = 16'h270E;
	localparam logic [15:0] CODE_COLD = 16'h270F;

	////////////////////////////////////////////////////////////////////////
	// Object type identifiers
	localparam logic [7:0] TID_SP = 8'h01;
	localparam logic [7:0] TID_DP = 8'h03;
	localparam logic [7:0] TID_ST = 8'h05;
	localparam logic [7:0] TID_BO = 8'h07;
	localparam logic [7:0] TID_ME_NORM = 8'h09;
	localparam logic [7:0] TID_ME_SCL = 8'h0B;
	localparam logic [7:0] TID_ME_FLT = 8'h0D;
	localparam logic [7:0] TID_IT = 8'h0F;
	localparam logic [7:0] TID_C_SC = 8'h2D;
	localparam logic [7:0] TID_C_DC = 8'h2E;
	localparam logic [7:0] TID_C_RC = 8'h2F;
	localparam logic [7:0] TID_C_SE_NORM = 8'h30;
	localparam logic [7:0] TID_C_SE_SCL = 8'h31;
	localparam logic [7:0] TID_C_SE_FLT = 8'h32;
	localparam logic [7:0] TID_C_BO = 8'h33;

	////////////////////////////////////////////////////////////////////////
	// Point addressing and value codes
	localparam int unsigned BIT_ADDR_SHIFT = 4;
	localparam logic [15:0] BIT_POS_MASK = 16'h000F;
	localparam logic [4:0] BYTE_HI_SHIFT = 5'h08;
	localparam logic [31:0] MASK_BIT = 32'h0000_0001;
	localparam logic [31:0] MASK_PAIR = 32'h0000_0003;
	localparam logic [31:0] MASK_BYTE = 32'h0000_00FF;
	localparam logic [31:0] MASK_WORD = 32'h0000_FFFF;
	localparam logic [31:0] MASK_DWORD = 32'hFFFF_FFFF;
	localparam logic [31:0] VAL_CODE_1 = 32'h0000_0001; // Off / next lower
	localparam logic [31:0] VAL_CODE_2 = 32'h0000_0002; // On / next higher

	////////////////////////////////////////////////////////////////////////
	// Types
	typedef struct packed {
		logic we;
		logic re;
		logic [12:0] addr;
		logic [15:0] data;
	} tcm_bus_s;

	typedef struct packed {
		logic [7:0] type_id;
		logic [15:0] addr;
	} tcm_pt_req_s;

	typedef enum logic [2:0] {
		K_NONE = 3'b000,
		K_BIT = 3'b001,
		K_PAIR = 3'b010,
		K_BYTE = 3'b011,
		K_WORD = 3'b100,
		K_DWORD = 3'b101
	} tcm_kind_e;

	typedef struct packed {
		tcm_kind_e kind;
		logic err;
		logic [12:0] word;
		logic [4:0] shift;
		logic [31:0] mask;
	} tcm_pt_map_s;

	typedef enum logic [2:0] {
		CMD_NONE = 3'b000,
		CMD_OFF = 3'b001,
		CMD_ON = 3'b010,
		CMD_LOWER = 3'b011,
		CMD_HIGHER = 3'b100,
		CMD_SET = 3'b101
	} tcm_cmd_e;

	typedef struct packed {
		logic valid;
		logic reject;
		tcm_cmd_e act;
	} tcm_cmd_s;

	typedef enum logic [3:0] {
		BLK_NONE = 4'b0000,
		BLK_USER = 4'b0001,
		BLK_LIST = 4'b0010,
		BLK_EVENT = 4'b0011,
		BLK_LIST_ERR = 4'b0100,
		BLK_TIME_GET = 4'b0101,
		BLK_TIME_SET = 4'b0110,
		BLK_RESTART = 4'b0111,
		BLK_UNKNOWN = 4'b1000
	} tcm_blk_e;

	typedef enum logic [1:0] {
		ST_IDLE = 2'b00,
		ST_WAIT = 2'b01
	} tcm_state_e;

endpackage
`default_nettype wire

/* tcm_point_map.sv */
`timescale 1ns/10ps
`default_nettype none
module tcm_point_map import tcm_pkg::*; (
	// Point request
	input wire tcm_pt_req_s i_req,
	// Mapped location
	output tcm_pt_map_s o_map
);

	////////////////////////////////////////////////////////////////////////
	// Storage kind of each object type
	function automatic tcm_kind_e kind_of(input logic [7:0] t);
		case (t)
			TID_SP, TID_C_SC: kind_of = K_BIT;
			TID_DP, TID_C_DC, TID_C_RC: kind_of = K_PAIR;
			TID_ST: kind_of = K_BYTE;
			TID_ME_NORM, TID_ME_SCL, TID_C_SE_NORM, TID_C_SE_SCL: kind_of = K_WORD;
			TID_BO, TID_ME_FLT, TID_IT, TID_C_SE_FLT, TID_C_BO: kind_of = K_DWORD;
			default: kind_of = K_NONE;
		endcase
	endfunction

	logic [16:0] idx;
	logic [16:0] last;
	tcm_kind_e kind;

	////////////////////////////////////////////////////////////////////////
	// Point address to word index, bit offset and width
	always_comb begin
		kind = kind_of(i_req.type_id);
		idx = '0;
		o_map.shift = '0;
		o_map.mask = '0;
		case (kind)
			K_BIT: begin
				idx = 17'({1'b0, i_req.addr} >> BIT_ADDR_SHIFT);
				o_map.shift = 5'(i_req.addr & BIT_POS_MASK);
				o_map.mask = MASK_BIT;
			end
			K_PAIR: begin
				idx = 17'({1'b0, i_req.addr} >> BIT_ADDR_SHIFT);
				o_map.shift = 5'(i_req.addr & BIT_POS_MASK);
				o_map.mask = MASK_PAIR;
			end
			K_BYTE: begin
				idx = 17'({1'b0, i_req.addr} >> 1);
				o_map.shift = i_req.addr[0] ? BYTE_HI_SHIFT : 5'h00;
				o_map.mask = MASK_BYTE;
			end
			K_WORD: begin
				idx = {1'b0, i_req.addr};
				o_map.mask = MASK_WORD;
			end
			K_DWORD: begin
				idx = {i_req.addr, 1'b0};
				o_map.mask = MASK_DWORD;
			end
			default: begin
				idx = '0;
			end
		endcase
		last = (kind == K_DWORD) ? 17'(idx + 17'h00001) : idx;
		o_map.kind = kind;
		o_map.err = (kind == K_NONE) || (last > {4'h0, DB_LAST});
		o_map.word = idx[12:0];
	end

endmodule
`default_nettype wire

/* tcm_data_map.sv */
// Function
// - Short float measured values (13) occupy two words as single precision.
// - Integrated totals (15) are signed 32-bit values across two words.
// - Single command (45): 0 is Off, 1 is On.
// - Double command (46): 1 Off, 2 On, 0 and 3 rejected.
// - Step command (47): 1 lower, 2 higher, 0 and 3 rejected.
// - Normalized (48) and scaled (49) setpoints use one signed word.
// - Float setpoint (50) and 32-bit bitstring (51) use two words.
// - Single point address is a bit address; word is address over sixteen.
// - Dual point uses two adjacent bits in word address over sixteen.
// - Step point address is a byte address; even is lower byte.
// - Bitstring, float and total address is a double word index.
// - Normalized and scaled measured address is the word index.
// - Block codes 9901 9902 9903 9950 9970 9971 9998 9999 are recognised.
// - Status area words 4000 to 4099 are published by the device.
// - Events fill 4200 to 4299, 9903 marks them; host clears to acknowledge.
// - Host controls through words 4100 to 4199, code in 4100.
// - Code 9998 in 4100 performs a warm restart.
// - Code 9999 performs a cold restart, same as warm.
// - Codes above 9900 request a special function.
// - Control word is cleared after a block is consumed.
// - User database is words 0 to 3999; higher words are control blocks.
`timescale 1ns/10ps
`default_nettype none
module tcm_data_map import tcm_pkg::*; (
	// Clock and reset
	input wire logic i_ref_clk,
	input wire logic i_rst,
	// Host controller word port
	input wire tcm_bus_s i_host,
	output logic [15:0] o_host_rdata_ff,
	// Protocol engine word port
	input wire tcm_bus_s i_eng,
	output logic [15:0] o_eng_rdata_ff,
	// Point access from the protocol engine
	input wire logic i_pt_req,
	input wire tcm_pt_req_s i_pt,
	output logic o_pt_valid_ff,
	output logic o_pt_err_ff,
	output logic [31:0] o_pt_data_ff,
	output var tcm_cmd_s o_cmd_ff,
	// Special function handshake
	output logic o_blk_req,
	output var tcm_blk_e o_blk_code_ff,
	input wire logic i_blk_done,
	output logic o_restart_ff,
	output logic o_blk_bad_ff,
	// Event delivery
	input wire logic i_evt_post,
	output logic o_evt_ready
);

	////////////////////////////////////////////////////////////////////////
	// Decoding helpers
	function automatic logic in_map(input logic [12:0] a);
		in_map = (a <= ADDR_LAST);
	endfunction

	function automatic tcm_blk_e classify(input logic [15:0] code);
		if (code <= CODE_SPECIAL_MIN) begin
			classify = BLK_NONE;
		end else begin
			case (code)
				CODE_USER_CMD: classify = BLK_USER;
				CODE_LIST_CMD: classify = BLK_LIST;
				CODE_EVENT: classify = BLK_EVENT;
				CODE_LIST_ERR: classify = BLK_LIST_ERR;
				CODE_TIME_GET: classify = BLK_TIME_GET;
				CODE_TIME_SET: classify = BLK_TIME_SET;
				CODE_WARM, CODE_COLD: classify = BLK_RESTART;
				default: classify = BLK_UNKNOWN;
			endcase
		end
	endfunction

	function automatic tcm_cmd_s decode_cmd(input logic [7:0] t, input logic [31:0] v);
		decode_cmd = '{valid: 1'b0, reject: 1'b0, act: CMD_NONE};
		case (t)
			TID_C_SC: begin
				decode_cmd.valid = 1'b1;
				decode_cmd.act = v[0] ? CMD_ON : CMD_OFF;
			end
			TID_C_DC: begin
				decode_cmd.valid = (v == VAL_CODE_1) || (v == VAL_CODE_2);
				decode_cmd.reject = !decode_cmd.valid;
				decode_cmd.act = (v == VAL_CODE_1) ? CMD_OFF : ((v == VAL_CODE_2) ? CMD_ON : CMD_NONE);
			end
			TID_C_RC: begin
				decode_cmd.valid = (v == VAL_CODE_1) || (v == VAL_CODE_2);
				decode_cmd.reject = !decode_cmd.valid;
				decode_cmd.act = (v == VAL_CODE_1) ? CMD_LOWER : ((v == VAL_CODE_2) ? CMD_HIGHER : CMD_NONE);
			end
			TID_C_SE_NORM, TID_C_SE_SCL, TID_C_SE_FLT, TID_C_BO: begin
				decode_cmd.valid = 1'b1;
				decode_cmd.act = CMD_SET;
			end
			default: begin
				decode_cmd.valid = 1'b0;
			end
		endcase
	endfunction

	////////////////////////////////////////////////////////////////////////
	// Shared word area
	logic [15:0] mem [MEM_WORDS];
	logic [15:0] ctrl_word;
	logic [15:0] evt_word;
	logic host_wr_ok;
	logic eng_wr_ok;
	logic ctrl_clear;
	logic evt_post_ok;
	tcm_state_e state_ff;
	tcm_state_e nxt_state;
	tcm_blk_e cls;
	tcm_pt_map_s pt_map;
	logic [31:0] pt_raw;
	logic [12:0] pt_word_hi;
	logic [7:0] pt_type_ff;

	assign ctrl_word = mem[CTRL_WORD];
	assign evt_word = mem[EVT_WORD];

	// Event area is free once the host has cleared the marker
	assign o_evt_ready = (evt_word != CODE_EVENT);
	assign evt_post_ok = i_evt_post && o_evt_ready;

	// Host may write the database, the control block and the event acknowledge only
	assign host_wr_ok = i_host.we && ((i_host.addr <= DB_LAST)
		|| ((i_host.addr >= CTRL_WORD) && (i_host.addr <= CTRL_LAST))
		|| (i_host.addr == EVT_WORD));

	// Engine publishes database and status; event body only while the area is free
	assign eng_wr_ok = i_eng.we && ((i_eng.addr <= STAT_LAST)
		|| ((i_eng.addr > EVT_WORD) && (i_eng.addr <= EVT_LAST) && o_evt_ready));

	// Write ports; later writes win, so a host code beats a clear and an event mark beats an ack
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			mem[CTRL_WORD] <= WORD_CLEAR;
			mem[EVT_WORD] <= WORD_CLEAR;
		end else begin
			if (eng_wr_ok) begin
				mem[i_eng.addr] <= i_eng.data;
			end
			if (ctrl_clear) begin
				mem[CTRL_WORD] <= WORD_CLEAR;
			end
			if (host_wr_ok) begin
				mem[i_host.addr] <= i_host.data;
			end
			if (evt_post_ok) begin
				mem[EVT_WORD] <= CODE_EVENT;
			end
		end
	end

	// Registered read ports; addresses past the area read as zero
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_host_rdata_ff <= WORD_CLEAR;
			o_eng_rdata_ff <= WORD_CLEAR;
		end else begin
			o_host_rdata_ff <= (i_host.re && in_map(i_host.addr)) ? mem[i_host.addr] : WORD_CLEAR;
			o_eng_rdata_ff <= (i_eng.re && in_map(i_eng.addr)) ? mem[i_eng.addr] : WORD_CLEAR;
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Control block sequencer
	assign cls = classify(ctrl_word);
	assign o_blk_req = (state_ff == ST_WAIT);

	// Next state and clear of the control word
	always_comb begin
		nxt_state = state_ff;
		ctrl_clear = 1'b0;
		case (state_ff)
			ST_IDLE: begin
				case (cls)
					BLK_NONE: nxt_state = ST_IDLE;
					BLK_RESTART, BLK_UNKNOWN: ctrl_clear = 1'b1;
					default: nxt_state = ST_WAIT;
				endcase
			end
			ST_WAIT: begin
				if (i_blk_done) begin
					ctrl_clear = 1'b1;
					nxt_state = ST_IDLE;
				end
			end
			default: nxt_state = ST_IDLE;
		endcase
	end

	// State register
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			state_ff <= ST_IDLE;
		end else begin
			state_ff <= nxt_state;
		end
	end

	// Block code to the engine, latched when a request is accepted
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_blk_code_ff <= BLK_NONE;
		end else if ((state_ff == ST_IDLE) && (nxt_state == ST_WAIT)) begin
			o_blk_code_ff <= cls;
		end
	end

	// Restart and unknown code pulses; warm and cold do the same reinitialisation
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_restart_ff <= 1'b0;
			o_blk_bad_ff <= 1'b0;
		end else begin
			o_restart_ff <= (state_ff == ST_IDLE) && (cls == BLK_RESTART);
			o_blk_bad_ff <= (state_ff == ST_IDLE) && (cls == BLK_UNKNOWN);
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Point access
	tcm_point_map u_point_map (
		.i_req(i_pt),
		.o_map(pt_map)
	);

	// Two words are fetched so pairs and double words come out whole, low word first
	assign pt_word_hi = 13'(pt_map.word + WORD_STEP);
	assign pt_raw = {mem[pt_word_hi], mem[pt_map.word]};

	// Point result and command decode
	always_ff @(posedge i_ref_clk) begin
		if (i_rst) begin
			o_pt_valid_ff <= 1'b0;
			o_pt_err_ff <= 1'b0;
			o_pt_data_ff <= '0;
			o_cmd_ff <= '{valid: 1'b0, reject: 1'b0, act: CMD_NONE};
			pt_type_ff <= '0;
		end else begin
			o_pt_valid_ff <= i_pt_req && !pt_map.err;
			o_pt_err_ff <= i_pt_req && pt_map.err;
			if (i_pt_req && !pt_map.err) begin
				o_pt_data_ff <= (pt_raw >> pt_map.shift) & pt_map.mask;
				o_cmd_ff <= decode_cmd(i_pt.type_id, (pt_raw >> pt_map.shift) & pt_map.mask);
				pt_type_ff <= i_pt.type_id;
			end
		end
	end

	////////////////////////////////////////////////////////////////////////
	// Checks
	default clocking cb @(posedge i_ref_clk);
	endclocking
	default disable iff (i_rst);

	sequence s_code_seen(logic [15:0] code);
		(state_ff == ST_IDLE) && (ctrl_word == code);
	endsequence

	sequence s_restart_done;
		o_restart_ff && !o_blk_req;
	endsequence

	chk_warm_restart: assert property (
		s_code_seen(CODE_WARM) and !(host_wr_ok && (i_host.addr == CTRL_WORD))
		|=> s_restart_done ##1 !o_restart_ff)
		else $error("warm restart code not handled");

	chk_cold_restart: assert property (
		s_code_seen(CODE_COLD) and !(host_wr_ok && (i_host.addr == CTRL_WORD))
		|=> s_restart_done and (ctrl_word == WORD_CLEAR))
		else $error("cold restart did not pulse and clear");

	chk_block_request: assert property (
		(s_code_seen(CODE_USER_CMD) or s_code_seen(CODE_TIME_SET))
		|=> o_blk_req && (o_blk_code_ff == $past(cls)) && !o_restart_ff)
		else $error("special block not requested");

	chk_plain_code: assert property (
		(state_ff == ST_IDLE) && (ctrl_word <= CODE_SPECIAL_MIN)
		|=> !o_blk_req && !o_restart_ff && !o_blk_bad_ff)
		else $error("ordinary code treated as special");

	chk_done_clear: assert property (
		o_blk_req && i_blk_done && !(host_wr_ok && (i_host.addr == CTRL_WORD))
		|=> (ctrl_word == WORD_CLEAR) && !o_blk_req)
		else $error("control word not cleared after block");

	chk_event_mark: assert property (
		i_evt_post && o_evt_ready |=> (evt_word == CODE_EVENT) && !o_evt_ready)
		else $error("event marker not written");

	chk_event_hold: assert property (
		!o_evt_ready && !(host_wr_ok && (i_host.addr == EVT_WORD))
		|=> !o_evt_ready && $stable(evt_word))
		else $error("pending events disturbed");

	chk_single_bit: assert property (
		o_pt_valid_ff && ((pt_type_ff == TID_SP) || (pt_type_ff == TID_C_SC))
		|-> (o_pt_data_ff[31:1] == '0))
		else $error("single point wider than one bit");

	chk_double_cmd: assert property (
		o_pt_valid_ff && (pt_type_ff == TID_C_DC)
		|-> (o_cmd_ff.reject == ((o_pt_data_ff == '0) || (o_pt_data_ff == MASK_PAIR))))
		else $error("double command code check wrong");

	chk_step_cmd: assert property (
		i_pt_req && !pt_map.err && (i_pt.type_id == TID_C_RC) && (((pt_raw >> pt_map.shift) & pt_map.mask) == VAL_CODE_2)
		|=> o_cmd_ff.valid && (o_cmd_ff.act == CMD_HIGHER))
		else $error("step command higher not decoded");

	chk_single_cmd: assert property (
		o_pt_valid_ff && (pt_type_ff == TID_C_SC)
		|-> o_cmd_ff.valid && (o_cmd_ff.act == (o_pt_data_ff[0] ? CMD_ON : CMD_OFF)))
		else $error("single command not decoded");

	chk_status_guard: assert property (
		i_host.we && (i_host.addr >= STAT_FIRST) && (i_host.addr <= STAT_LAST) |-> !host_wr_ok)
		else $error("host write reached the status area");

	chk_ctrl_owner: assert property (
		i_eng.we && (i_eng.addr >= CTRL_WORD) && (i_eng.addr <= EVT_WORD) |-> !eng_wr_ok)
		else $error("engine write reached the control area");

	chk_event_body: assert property (
		i_eng.we && (i_eng.addr > EVT_WORD) && (i_eng.addr <= EVT_LAST) && !o_evt_ready |-> !eng_wr_ok)
		else $error("event body overwritten while pending");

	chk_event_ack: assert property (
		host_wr_ok && (i_host.addr == EVT_WORD) && (i_host.data != CODE_EVENT) && !evt_post_ok
		|=> o_evt_ready)
		else $error("host acknowledge did not free the event area");

	chk_unknown_code: assert property (
		(state_ff == ST_IDLE) && (cls == BLK_UNKNOWN) && !(host_wr_ok && (i_host.addr == CTRL_WORD))
		|=> o_blk_bad_ff && !o_blk_req && (ctrl_word == WORD_CLEAR))
		else $error("unknown special code not refused");

	chk_block_hold: assert property (
		o_blk_req && !i_blk_done |=> o_blk_req && $stable(o_blk_code_ff))
		else $error("special block request dropped early");

endmodule
`default_nettype wire

/* tcm_host_model.sv */
`timescale 1ns/10ps
`default_nettype none
module tcm_host_model import tcm_pkg::*; (
	// Clock
	input wire logic i_ref_clk,
	// Read data back from the shared area
	input wire logic [15:0] i_rdata,
	// Host word port
	output var tcm_bus_s o_host
);
	////////////////////////////////////////////////////////////////////////
	// Bus starts idle
	initial begin
		o_host = '0;
	end

	// Released bus shows inverted address and data so stale values never match
	task automatic idle();
		o_host <= '{we: 1'h0, re: 1'h0, addr: ~o_host.addr, data: ~o_host.data};
	endtask

	// One write, taken at the second edge
	task automatic wr(input logic [12:0] a, input logic [15:0] d);
		@(posedge i_ref_clk);
		o_host <= '{we: 1'h1, re: 1'h0, addr: a, data: d};
		@(posedge i_ref_clk);
		idle();
	endtask

	// One read, data registered at the taken edge and sampled one time unit after it
	task automatic rd(input logic [12:0] a, output logic [15:0] d);
		@(posedge i_ref_clk);
		o_host <= '{we: 1'h0, re: 1'h1, addr: a, data: ~o_host.data};
		@(posedge i_ref_clk);
		idle();
		#1;
		d = i_rdata;
	endtask

	// Reads the first event body word, then frees the block; gap stands for a slow scan
	task automatic take_events(input int gap, output logic [15:0] first);
		repeat (gap) @(posedge i_ref_clk);
		rd(EVT_WORD + WORD_STEP, first);
		wr(EVT_WORD, WORD_CLEAR);
	endtask

	// Special function request through the control word
	task automatic send_block(input logic [15:0] code);
		wr(CTRL_WORD, code);
	endtask
endmodule
`default_nettype wire

/* test_tcm_data_map.sv */
`timescale 1ns/10ps
`default_nettype none
module test_tcm_data_map import tcm_pkg::*;;
	logic ref_clk = 1'h0;
	logic rst, pt_req, blk_done, evt_post, pt_valid, pt_err, blk_req, restart, blk_bad, evt_ready;
	tcm_bus_s host_bus, eng;
	tcm_pt_req_s pt;
	tcm_cmd_s cmd;
	tcm_blk_e blk_code;
	logic [15:0] host_rdata, eng_rdata, w;
	logic [31:0] pt_data;
	int num_errors = 0;
	int num_checks = 0;

	////////////////////////////////////////////////////////////////////////
	// Clock, design and host controller
	always #2 ref_clk = ~ref_clk;

	tcm_data_map dut (.i_ref_clk(ref_clk), .i_rst(rst), .i_host(host_bus), .o_host_rdata_ff(host_rdata),
		.i_eng(eng), .o_eng_rdata_ff(eng_rdata), .i_pt_req(pt_req), .i_pt(pt), .o_pt_valid_ff(pt_valid),
		.o_pt_err_ff(pt_err), .o_pt_data_ff(pt_data), .o_cmd_ff(cmd), .o_blk_req(blk_req),
		.o_blk_code_ff(blk_code), .i_blk_done(blk_done), .o_restart_ff(restart), .o_blk_bad_ff(blk_bad),
		.i_evt_post(evt_post), .o_evt_ready(evt_ready));

	tcm_host_model host (.i_ref_clk(ref_clk), .i_rdata(host_rdata), .o_host(host_bus));

	////////////////////////////////////////////////////////////////////////
	// Report and compare
	task automatic end_of_test();
		$display("Checks %0d, errors %0d", num_checks, num_errors);
		if (num_errors == 0 && num_checks > 0) begin
			$display("[ PASS ]");
		end else begin
			$display("[ FAIL ]");
		end
		$finish;
	endtask

	task automatic cmp_val(input string name, input logic [31:0] exp, input logic [31:0] got);
		num_checks++;
		if (got !== exp) begin
			num_errors++;
			$display("Error %s expected %h seen %h", name, exp, got);
		end
	endtask

	task automatic cmp_bit(input string name, input logic exp, input logic got);
		cmp_val(name, {31'h0, exp}, {31'h0, got});
	endtask

	// Bounded wait for blk_req (0), restart (1) or bad code (2)
	task automatic wait_for(input int s);
		for (int n = 0; n < 10; n++) begin
			@(posedge ref_clk);
			#1;
			if ((s == 0 ? blk_req : s == 1 ? restart : blk_bad) === 1'h1) begin
				return;
			end
		end
		num_errors++;
		$display("Error wait %0d expected pulse seen none", s);
		end_of_test();
	endtask

	////////////////////////////////////////////////////////////////////////
	// Engine side drivers
	task automatic eng_wr(input logic [12:0] a, input logic [15:0] d);
		@(posedge ref_clk);
		eng <= '{we: 1'h1, re: 1'h0, addr: a, data: d};
		@(posedge ref_clk);
		eng <= '{we: 1'h0, re: 1'h0, addr: ~a, data: ~d};
	endtask

	task automatic pt_chk(input logic [7:0] t, input logic [15:0] a, input logic [31:0] exp, input logic err);
		@(posedge ref_clk);
		pt_req <= 1'h1;
		pt <= '{type_id: t, addr: a};
		@(posedge ref_clk);
		pt_req <= 1'h0;
		#1;
		cmp_bit("pt_err", err, pt_err);
		if (!err) begin
			cmp_bit("pt_valid", 1'h1, pt_valid);
			cmp_val("pt_data", exp, pt_data);
		end
	endtask

	task automatic cmd_chk(input logic [7:0] t, input logic [15:0] a, input logic [15:0] v, input logic rej,
		input tcm_cmd_e act);
		eng_wr(13'h0064, v);
		pt_chk(t, a, {16'h0, v}, 1'h0);
		cmp_bit("cmd_valid", !rej, cmd.valid);
		cmp_bit("cmd_reject", rej, cmd.reject);
		if (!rej) begin
			cmp_val("cmd_act", 32'(act), 32'(cmd.act));
		end
	endtask

	////////////////////////////////////////////////////////////////////////
	// Scenarios
	task automatic t_store();
		host.wr(13'h0000, 16'h1234);
		host.wr(DB_LAST, 16'hBEEF);
		host.rd(DB_LAST, w);
		cmp_val("db_last", 32'h0000BEEF, {16'h0, w});
		@(posedge ref_clk);
		eng <= '{we: 1'h0, re: 1'h1, addr: DB_LAST, data: 16'h0000};
		@(posedge ref_clk);
		eng <= '{we: 1'h0, re: 1'h0, addr: ~DB_LAST, data: 16'hFFFF};
		#1;
		cmp_val("eng_rdata", 32'h0000BEEF, {16'h0, eng_rdata});
		eng_wr(STAT_FIRST, 16'h5A5A);
		host.wr(STAT_FIRST, 16'h0000);
		host.rd(STAT_FIRST, w);
		cmp_val("status_word", 32'h00005A5A, {16'h0, w});
		host.rd(13'h10CC, w);
		cmp_val("beyond_map", 32'h0, {16'h0, w});
	endtask

	task automatic t_points();
		logic [7:0] dw [5] = '{TID_BO, TID_ME_FLT, TID_IT, TID_C_SE_FLT, TID_C_BO};
		eng_wr(13'h0064, 16'hA5C3);
		eng_wr(13'h0065, 16'h8001);
		eng_wr(13'h0F9E, 16'h0001);
		pt_chk(TID_SP, 16'h0640, 32'h1, 1'h0);
		pt_chk(TID_SP, 16'h0642, 32'h0, 1'h0);
		pt_chk(TID_DP, 16'h0640, 32'h3, 1'h0);
		pt_chk(TID_DP, 16'h0642, 32'h0, 1'h0);
		pt_chk(TID_ST, 16'h00C8, 32'hC3, 1'h0);
		pt_chk(TID_ST, 16'h00C9, 32'hA5, 1'h0);
		pt_chk(TID_ME_NORM, 16'h0064, 32'hA5C3, 1'h0);
		pt_chk(TID_ME_SCL, 16'h0064, 32'hA5C3, 1'h0);
		foreach (dw[i]) begin
			pt_chk(dw[i], 16'h0032, 32'h8001A5C3, 1'h0);
		end
		pt_chk(TID_IT, 16'h07CF, 32'hBEEF0001, 1'h0);
		pt_chk(TID_IT, 16'h07D0, 32'h0, 1'h1);
		pt_chk(TID_ME_NORM, 16'h0FA0, 32'h0, 1'h1);
	endtask

	task automatic t_commands();
		for (int v = 0; v < 4; v++) begin
			cmd_chk(TID_C_DC, 16'h0640, 16'(v), v == 0 || v == 3, v == 1 ? CMD_OFF : CMD_ON);
			cmd_chk(TID_C_RC, 16'h0640, 16'(v), v == 0 || v == 3, v == 1 ? CMD_LOWER : CMD_HIGHER);
			if (v < 2) begin
				cmd_chk(TID_C_SC, 16'h0640, 16'(v), 1'h0, v == 1 ? CMD_ON : CMD_OFF);
			end
		end
		cmd_chk(TID_C_SE_NORM, 16'h0064, 16'h8000, 1'h0, CMD_SET);
		cmd_chk(TID_C_SE_SCL, 16'h0064, 16'h7FFF, 1'h0, CMD_SET);
	endtask

	task automatic t_blocks();
		logic [15:0] c [6] = '{CODE_USER_CMD, CODE_LIST_CMD, CODE_EVENT, CODE_LIST_ERR, CODE_TIME_GET, CODE_TIME_SET};
		tcm_blk_e k [6] = '{BLK_USER, BLK_LIST, BLK_EVENT, BLK_LIST_ERR, BLK_TIME_GET, BLK_TIME_SET};
		logic [15:0] p [3] = '{CODE_WARM, CODE_COLD, 16'h26B1};
		foreach (c[i]) begin
			host.send_block(c[i]);
			wait_for(0);
			cmp_val("blk_code", 32'(k[i]), 32'(blk_code));
			@(posedge ref_clk);
			blk_done <= 1'h1;
			@(posedge ref_clk);
			blk_done <= 1'h0;
			#1;
			cmp_bit("blk_req", 1'h0, blk_req);
			host.rd(CTRL_WORD, w);
			cmp_val("ctrl_clear", 32'h0, {16'h0, w});
		end
		foreach (p[i]) begin
			host.send_block(p[i]);
			wait_for(i == 2 ? 2 : 1);
			@(posedge ref_clk);
			#1;
			cmp_bit("pulse_end", 1'h0, i == 2 ? blk_bad : restart);
			host.rd(CTRL_WORD, w);
			cmp_val("ctrl_clear", 32'h0, {16'h0, w});
		end
		host.send_block(CODE_SPECIAL_MIN);
		repeat (4) @(posedge ref_clk);
		#1;
		cmp_bit("plain_req", 1'h0, blk_req);
		host.rd(CTRL_WORD, w);
		cmp_val("plain_data", 32'h26AC, {16'h0, w});
		host.wr(CTRL_WORD, WORD_CLEAR);
	endtask

	task automatic t_events();
		eng_wr(EVT_WORD + WORD_STEP, 16'h1111);
		for (int n = 0; n < 2; n++) begin
			@(posedge ref_clk);
			evt_post <= 1'h1;
			@(posedge ref_clk);
			evt_post <= 1'h0;
			#1;
			cmp_bit("evt_ready", 1'h0, evt_ready);
			host.rd(EVT_WORD, w);
			cmp_val("evt_mark", 32'h26AF, {16'h0, w});
			eng_wr(EVT_WORD + WORD_STEP, 16'h2222);
			host.take_events(n == 0 ? 6 : 0, w);
			cmp_val("evt_data", n == 0 ? 32'h1111 : 32'h3333, {16'h0, w});
			@(posedge ref_clk);
			#1;
			cmp_bit("evt_ready", 1'h1, evt_ready);
			eng_wr(EVT_WORD + WORD_STEP, 16'h3333);
		end
	endtask

	// Reset in mid-run drops a waiting block and a pending event mark
	task automatic t_reset();
		host.send_block(CODE_USER_CMD);
		wait_for(0);
		@(posedge ref_clk);
		evt_post <= 1'h1;
		@(posedge ref_clk);
		evt_post <= 1'h0;
		rst <= 1'h1;
		#1;
		cmp_bit("pre_rst_ready", 1'h0, evt_ready);
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		#1;
		cmp_bit("rst_ready", 1'h1, evt_ready);
		cmp_bit("rst_req", 1'h0, blk_req);
		cmp_bit("rst_restart", 1'h0, restart);
		host.rd(CTRL_WORD, w);
		cmp_val("rst_ctrl", 32'h0, {16'h0, w});
	endtask

	////////////////////////////////////////////////////////////////////////
	// Main sequence
	initial begin
		rst <= 1'h1;
		eng <= '0;
		pt <= '0;
		pt_req <= 1'h0;
		blk_done <= 1'h0;
		evt_post <= 1'h0;
		repeat (4) @(posedge ref_clk);
		rst <= 1'h0;
		#1;
		cmp_bit("reset_ready", 1'h1, evt_ready);
		cmp_bit("reset_req", 1'h0, blk_req);
		t_store();
		t_points();
		t_commands();
		t_blocks();
		t_events();
		t_reset();
		end_of_test();
	end
endmodule
`default_nettype wire
